// file: common/mrc_defines.svh
// mrc_defines.svh: offsets, field positions, reset values and timing counts
// assumes a 20 MHz core clock; included by bare name
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
`define MRC_CLK_NS 50
// register offsets (byte addresses, one word each)
`define MRC_OFS_CMD 4'h0
`define MRC_OFS_CA_VREF 4'h4
`define MRC_OFS_HC_CTRL 4'h8
`define MRC_OFS_STATUS 4'hC
// field positions
`define MRC_CA_VREF_VAL_MSB 5
`define MRC_CA_VREF_RANGE_BIT 6
`define MRC_HC_MODE_BIT 3
// reset values
`define MRC_CA_VREF_RST 7'h4D
`define MRC_HC_CTRL_RST 8'h00
// mode register addresses carried by the command word
`define MRC_MA_CA_VREF 6'h0C
`define MRC_MA_HC_CTRL 6'h0D
// settling times, max, in ns; counts round down, at least one cycle
`define MRC_HC_ENABLE_NS 200
`define MRC_HC_DISABLE_NS 100
`define MRC_VREF_SHORT_NS 100
`define MRC_CYC_DN(ns) (((ns) / `MRC_CLK_NS) < 1 ? 1 : ((ns) / `MRC_CLK_NS))
`define MRC_HC_ENABLE_CYC `MRC_CYC_DN(`MRC_HC_ENABLE_NS)
`define MRC_HC_DISABLE_CYC `MRC_CYC_DN(`MRC_HC_DISABLE_NS)
`define MRC_VREF_SHORT_CYC `MRC_CYC_DN(`MRC_VREF_SHORT_NS)
`endif

// file: common/mrc_pkg.sv
// mrc_pkg.sv: types shared by the mode register block
// assumes nothing of its surroundings
package mrc_pkg;
  typedef enum logic [1:0] {
    MRC_CMD_NONE,
    MRC_CMD_READ,
    MRC_CMD_WRITE
  } mrc_cmd_type;
  typedef enum {
    MRC_IDLE,
    MRC_SETTLE
  } mrc_state_type;
endpackage

// file: core/mrc_mode_register.sv
// mrc_mode_register.sv: mode register read/write command handling for the device
// assumes an Avalon-MM master on clk and a command strobe from a link clock on a pin
//
// Overview of operation
// - bank state before a mode register command is kept once it completes.
// - writing one to high-current bit enters high-current mode; zero leaves it.
// - reference voltage range and value changes accepted regardless of high-current mode.
// - command/address vref register holds six-bit value and range select in bit six.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "mrc_defines.svh"
module mrc_mode_register
  import mrc_pkg::*;
#(
  parameter int HC_ENABLE_CYC = `MRC_HC_ENABLE_CYC,
  parameter int HC_DISABLE_CYC = `MRC_HC_DISABLE_CYC,
  parameter int VREF_SHORT_CYC = `MRC_VREF_SHORT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // link side: command sampled on rising edges of the link clock pin
  input wire logic linkClk,
  input wire logic cmdValid,
  input wire logic cmdIsWrite,
  input wire logic [5:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic [7:0] readData,
  output logic readDataValid,
  // device state
  output logic hcMode,
  output logic [5:0] caVrefValue,
  output logic caVrefRange,
  output logic settleBusy,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest
);
  initial begin
    if (HC_ENABLE_CYC < 1 || HC_DISABLE_CYC < 1 || VREF_SHORT_CYC < 1 ||
        HC_ENABLE_CYC > 65535 || HC_DISABLE_CYC > 65535 || VREF_SHORT_CYC > 65535)
      $error("mrc_mode_register: settle counts out of range");
  end

  logic [2:0] lclkSync_reg;
  logic [1:0] validSync_reg;
  logic [1:0] writeSync_reg;
  logic [5:0] addrSync0_reg, addrSync1_reg;
  logic [7:0] dataSync0_reg, dataSync1_reg;
  logic [6:0] caVref_reg;
  logic [7:0] hcCtrl_reg;
  logic [7:0] readData_reg;
  logic readDataValid_reg;
  logic [15:0] settleCnt_reg;
  logic [15:0] vrefCnt_reg;
  logic [31:0] avsReaddata_reg;
  logic avsAck_reg;
  logic [15:0] cmdCount_reg;
  mrc_state_type state_reg;
  mrc_cmd_type cmdKind;
  logic linkRise;
  logic swWrite;
  logic [7:0] swData;
  logic [5:0] swAddr;

  // two-stage synchronisers; only the second stage and later are read
  always_ff @(posedge clk) begin
    lclkSync_reg <= {lclkSync_reg[1:0], linkClk};
    validSync_reg <= {validSync_reg[0], cmdValid};
    writeSync_reg <= {writeSync_reg[0], cmdIsWrite};
    addrSync0_reg <= cmdAddr;
    addrSync1_reg <= addrSync0_reg;
    dataSync0_reg <= cmdData;
    dataSync1_reg <= dataSync0_reg;
  end

  // link inputs are stable across a link edge, so sampling synced copies at the edge is safe
  assign linkRise = lclkSync_reg[1] & ~lclkSync_reg[2];
  always_comb begin
    cmdKind = MRC_CMD_NONE;
    if (linkRise && validSync_reg[1])
      cmdKind = writeSync_reg[1] ? MRC_CMD_WRITE : MRC_CMD_READ;
  end

  // software may also issue a mode register write through the command word
  // it lands on the edge at which waitrequest is seen low, never on the wait cycle
  assign swWrite = avsWrite && avsAck_reg && avsAddress == `MRC_OFS_CMD;
  assign swAddr = avsWritedata[13:8];
  assign swData = avsWritedata[7:0];

  // mode registers; bank state is never touched here, so it survives the command
  always_ff @(posedge clk) begin
    if (rst) begin
      caVref_reg <= `MRC_CA_VREF_RST;
      hcCtrl_reg <= `MRC_HC_CTRL_RST;
    end else if (cmdKind == MRC_CMD_WRITE) begin
      if (addrSync1_reg == `MRC_MA_CA_VREF)
        caVref_reg <= dataSync1_reg[`MRC_CA_VREF_RANGE_BIT:0];
      if (addrSync1_reg == `MRC_MA_HC_CTRL)
        hcCtrl_reg <= dataSync1_reg;
    end else if (swWrite) begin
      if (swAddr == `MRC_MA_CA_VREF)
        caVref_reg <= swData[`MRC_CA_VREF_RANGE_BIT:0];
      if (swAddr == `MRC_MA_HC_CTRL)
        hcCtrl_reg <= swData;
    end
  end

  assign hcMode = hcCtrl_reg[`MRC_HC_MODE_BIT];
  assign caVrefValue = caVref_reg[`MRC_CA_VREF_VAL_MSB:0];
  assign caVrefRange = caVref_reg[`MRC_CA_VREF_RANGE_BIT];

  // settle window after a high-current mode change; shown so software can wait it out
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= MRC_IDLE;
      settleCnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        MRC_IDLE: begin
          if ((cmdKind == MRC_CMD_WRITE && addrSync1_reg == `MRC_MA_HC_CTRL &&
               dataSync1_reg[`MRC_HC_MODE_BIT] != hcMode) ||
              (cmdKind != MRC_CMD_WRITE && swWrite && swAddr == `MRC_MA_HC_CTRL &&
               swData[`MRC_HC_MODE_BIT] != hcMode)) begin
            state_reg <= MRC_SETTLE;
            settleCnt_reg <= hcMode ? 16'(HC_DISABLE_CYC) : 16'(HC_ENABLE_CYC);
          end
        end
        MRC_SETTLE: begin
          if (settleCnt_reg <= 16'h0001) begin
            state_reg <= MRC_IDLE;
            settleCnt_reg <= 16'h0000;
          end else begin
            settleCnt_reg <= settleCnt_reg - 16'h0001;
          end
        end
        default: state_reg <= MRC_IDLE;
      endcase
    end
  end

  // vref step timer restarted by each vref register write
  always_ff @(posedge clk) begin
    if (rst)
      vrefCnt_reg <= 16'h0000;
    else if ((cmdKind == MRC_CMD_WRITE && addrSync1_reg == `MRC_MA_CA_VREF) ||
             (swWrite && swAddr == `MRC_MA_CA_VREF))
      vrefCnt_reg <= 16'(VREF_SHORT_CYC);
    else if (vrefCnt_reg != 16'h0000)
      vrefCnt_reg <= vrefCnt_reg - 16'h0001;
  end

  assign settleBusy = (state_reg == MRC_SETTLE) || (vrefCnt_reg != 16'h0000);

  // mode register read answer; unmapped addresses return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      readData_reg <= 8'h00;
      readDataValid_reg <= 1'b0;
    end else begin
      readDataValid_reg <= (cmdKind == MRC_CMD_READ);
      if (cmdKind == MRC_CMD_READ) begin
        if (addrSync1_reg == `MRC_MA_CA_VREF)
          readData_reg <= {1'b0, caVref_reg};
        else if (addrSync1_reg == `MRC_MA_HC_CTRL)
          readData_reg <= hcCtrl_reg;
        else
          readData_reg <= 8'h00;
      end
    end
  end
  assign readData = readData_reg;
  assign readDataValid = readDataValid_reg;

  // count of link commands taken, for software observation
  always_ff @(posedge clk) begin
    if (rst)
      cmdCount_reg <= 16'h0000;
    else if (cmdKind != MRC_CMD_NONE)
      cmdCount_reg <= cmdCount_reg + 16'h0001;
  end

  // bus slave: one wait cycle, answer on the second cycle of each access
  always_ff @(posedge clk) begin
    if (rst) begin
      avsAck_reg <= 1'b0;
      avsReaddata_reg <= 32'h00000000;
    end else begin
      avsAck_reg <= (avsRead || avsWrite) && !avsAck_reg;
      if (avsRead && !avsAck_reg) begin
        case (avsAddress)
          `MRC_OFS_CA_VREF: avsReaddata_reg <= {25'h0000000, caVref_reg};
          `MRC_OFS_HC_CTRL: avsReaddata_reg <= {24'h000000, hcCtrl_reg};
          `MRC_OFS_STATUS: avsReaddata_reg <= {cmdCount_reg, 14'h0000, hcMode, settleBusy};
          default: avsReaddata_reg <= 32'h00000000;
        endcase
      end
    end
  end
  assign avsWaitrequest = (avsRead || avsWrite) && !avsAck_reg;
  assign avsReaddata = avsReaddata_reg;
endmodule

// file: test/mrc_mode_register_monitor.sv
// mrc_mode_register_monitor.sv: port checks for the mode register block
// assumes only the top module's ports; attached by bind
`timescale 1ns/1ps
module mrc_mode_register_monitor
  import mrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic readDataValid,
  input wire logic hcMode,
  input wire logic [5:0] caVrefValue,
  input wire logic caVrefRange,
  input wire logic settleBusy,
  input wire logic [3:0] avsAddress,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic avsWaitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // accepted command-word writes to the two mode registers; a link write in the same cycle wins
  wire logic hcWr = avsWrite && !avsWaitrequest && avsAddress == 4'h0 && avsWritedata[13:8] == 6'h0D;
  wire logic vrWr = avsWrite && !avsWaitrequest && avsAddress == 4'h0 && avsWritedata[13:8] == 6'h0C;
  hc_bit_write_a: assert property ((hcWr && !$past(cmdValid, 2)) |=> hcMode == $past(avsWritedata[3]))
    else $error("hc mode does not follow the written bit");
  vref_write_a: assert property ((vrWr && !$past(cmdValid, 2)) |=> {caVrefRange, caVrefValue} == $past(avsWritedata[6:0]))
    else $error("ca vref fields do not follow the write");
  hc_enable_settle_a: assert property ($rose(hcMode) |-> settleBusy [*4])
    else $error("enable settle window too short");
  hc_disable_settle_a: assert property ($fell(hcMode) |-> settleBusy [*2])
    else $error("disable settle window too short");
  // the mode changes only when some party wrote it
  state_kept_a: assert property (!$stable(hcMode) |-> $past(avsWrite) || $past(cmdValid))
    else $error("hc mode changed without a command");
  read_pulse_a: assert property (readDataValid |=> !readDataValid)
    else $error("read answer longer than one cycle");
endmodule
bind mrc_mode_register mrc_mode_register_monitor mrc_mode_register_monitor_i (.clk(clk), .rst(rst),
  .cmdValid(cmdValid), .readDataValid(readDataValid), .hcMode(hcMode), .caVrefValue(caVrefValue),
  .caVrefRange(caVrefRange), .settleBusy(settleBusy), .avsAddress(avsAddress), .avsWrite(avsWrite),
  .avsWritedata(avsWritedata), .avsWaitrequest(avsWaitrequest));

// file: test/mrc_ctrl_model.sv
// mrc_ctrl_model.sv: memory controller issuing mode register commands on the link
// assumes the link clock stands still between frames
`timescale 1ns/1ps
module mrc_ctrl_model
  import mrc_pkg::*;
(
  input wire logic settleBusy,
  output logic linkClk,
  output logic cmdValid,
  output logic cmdIsWrite,
  output logic [5:0] cmdAddr,
  output logic [7:0] cmdData
);
  initial begin
    linkClk = 1'b0;
    cmdValid = 1'b0;
    cmdIsWrite = 1'b0;
    cmdAddr = 6'h00;
    cmdData = 8'h00;
  end
  // one frame: command set up half a link period before the single rising edge
  task automatic send(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (settleBusy !== 1'b0 && n < 100) begin
      #50;
      n++;
    end
    // a settle window that never ends is a failure of the block
    if (settleBusy !== 1'b0)
      mrc_mode_register_tb.num_errors++;
    cmdValid = 1'b1;
    cmdIsWrite = wr;
    cmdAddr = a;
    cmdData = d;
    #200 linkClk = 1'b1;
    #200 linkClk = 1'b0;
    #200 cmdValid = 1'b0;
    cmdAddr = ~a; // released lines show the inverse, not the old value
    cmdData = ~d;
    #4000;
  endtask
endmodule

// file: test/mrc_mode_register_tb.sv
// mrc_mode_register_tb.sv: self-checking bench for the mode register block
// assumes the controller model and the bound monitor
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t got %h", $time, a); end end
module mrc_mode_register_tb
  import mrc_pkg::*;
;
  logic clk, rst, linkClk, cmdValid, cmdIsWrite, readDataValid, hcMode, caVrefRange, settleBusy;
  logic avsRead, avsWrite, avsWaitrequest;
  logic [5:0] cmdAddr, caVrefValue;
  logic [7:0] cmdData, readData, lastRd;
  logic [3:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  int num_errors = 0;
  int checked = 0;
  mrc_mode_register mrc_mode_register_i (.clk(clk), .rst(rst), .linkClk(linkClk), .cmdValid(cmdValid),
    .cmdIsWrite(cmdIsWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .readData(readData),
    .readDataValid(readDataValid), .hcMode(hcMode), .caVrefValue(caVrefValue), .caVrefRange(caVrefRange),
    .settleBusy(settleBusy), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));
  mrc_ctrl_model mrc_ctrl_model_i (.settleBusy(settleBusy), .linkClk(linkClk), .cmdValid(cmdValid),
    .cmdIsWrite(cmdIsWrite), .cmdAddr(cmdAddr), .cmdData(cmdData));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // the read answer is a one-cycle pulse, so it is caught here
  always @(posedge clk) if (readDataValid === 1'b1) lastRd <= readData;
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one Avalon cycle; held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (avsWaitrequest !== 1'b0) begin
      num_errors++;
      print_verdict();
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic t_reset();
    `CHK({caVrefRange, caVrefValue}, 7'h4D)
    `CHK(hcMode, 1'b0)
    bus(1'b0, 4'h4, 32'h00000000);
    `CHK(rd, 32'h0000004D)
    bus(1'b0, 4'h2, 32'h00000000);
    `CHK(rd, 32'h00000000)
    $display("reset test done");
  endtask
  task automatic t_hc_link();
    mrc_ctrl_model_i.send(1'b1, 6'h0D, 8'h08);
    `CHK(hcMode, 1'b1)
    mrc_ctrl_model_i.send(1'b0, 6'h0D, 8'h00);
    `CHK(lastRd, 8'h08)
    bus(1'b0, 4'hC, 32'h00000000);
    `CHK(rd[1], 1'b1)
    `CHK(rd[31:16], 16'h0002)
    mrc_ctrl_model_i.send(1'b1, 6'h0D, 8'h00);
    `CHK(hcMode, 1'b0)
    $display("hc link test done");
  endtask
  task automatic t_vref();
    mrc_ctrl_model_i.send(1'b1, 6'h0C, 8'h2A);
    `CHK({caVrefRange, caVrefValue}, 7'h2A)
    bus(1'b1, 4'h0, 32'h00000D08);
    `CHK(hcMode, 1'b1)
    `CHK(settleBusy, 1'b1)
    bus(1'b1, 4'h0, 32'h00000C55);
    `CHK({caVrefRange, caVrefValue}, 7'h55)
    bus(1'b1, 4'h0, 32'h00000C3F);
    bus(1'b0, 4'h4, 32'h00000000);
    `CHK(rd, 32'h0000003F)
    mrc_ctrl_model_i.send(1'b0, 6'h0C, 8'h00);
    `CHK(lastRd, 8'h3F)
    $display("vref test done");
  endtask
  initial begin
    rst = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h00000000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_hc_link();
    t_vref();
    print_verdict();
  end
endmodule
